// file: verilog/pll_cfg_consts.vh
// constants for the dual-loop configuration and lock-detect block
// Overview of operation
// - register 23 readback only; count at 23:14
// - tracked dac value reported in count field
// - first-loop window code picks 5.5-40 ns
// - first-loop lock after programmed in-window cycles
// - dac update clock divides by 1..1023
// - second-loop lock after programmed in-window cycles
// - one bit doubles the second-loop reference
// - second pump 100-3200 uA; hiz overrides gain
// - first pump polarity bit selects slope
// - first pump 100-1600 uA; hiz overrides gain
// - per-input pre-divider divides by 1,2,4,8
// - active input switch applies its own pre-divider
// - first-loop reference divides by 1..16383
// - second-loop reference divides by 12-bit value
// - feedback delay 205 ps steps, outputs lead
// - reference delay 205 ps steps, outputs lag
`ifndef PLL_CFG_CONSTS_VH
`define PLL_CFG_CONSTS_VH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define ADDR_DAC_COUNT_READBACK  5'h17
`define ADDR_LOOP_FILTER_DELAY   5'h18
`define ADDR_DAC_DIV_LOCK_COUNT  5'h19
`define ADDR_SECOND_LOOP_CTRL    5'h1a
`define ADDR_FIRST_LOOP_CTRL     5'h1b
`define ADDR_SECOND_LOOP_REF_DIV 5'h1c
`define ADDR_READBACK_SELECT     5'h1f
// ----------------------------------------
// field positions
// ----------------------------------------
`define F_ADDR          4:0
`define F_DAC_COUNT     23:14
`define F_CAP_C4        31:28
`define F_CAP_C3        27:24
`define F_RES_R4        22:20
`define F_RES_R3        18:16
`define F_FB_DELAY      14:12
`define F_REF_DELAY     10:8
`define F_WINDOW1       7:6
`define F_DAC_DIV       31:22
`define F_LOCK_COUNT    19:6
`define F_WINDOW2       31:30
`define F_DOUBLER       29
`define F_PUMP_POL      28
`define F_PUMP_GAIN     27:26
`define F_PUMP_HIZ      5
`define F_PREDIV1       23:22
`define F_PREDIV0       21:20
`define F_REF_DIV1      19:6
`define F_REF_DIV2      31:20
`define F_RB_ADDR       20:16
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_REG         32'h0000_0000
// ----------------------------------------
// lock windows (ps) and step sizes
// ----------------------------------------
`define WIN1_PS_0       16'd5500
`define WIN1_PS_1       16'd10000
`define WIN1_PS_2       16'd18600
`define WIN1_PS_3       16'd40000
`define WIN2_PS         16'd3700
`define DELAY_STEP_PS   11'd205
// ----------------------------------------
// pump currents (uA)
// ----------------------------------------
`define P2_UA_0         12'd100
`define P2_UA_1         12'd400
`define P2_UA_2         12'd1600
`define P2_UA_3         12'd3200
`define P1_UA_0         12'd100
`define P1_UA_1         12'd200
`define P1_UA_2         12'd400
`define P1_UA_3         12'd1600
`endif

// file: verilog/tick_divider.v
// divides a stream of one-cycle ticks by a programmable value
`timescale 1ns/1ns
`default_nettype none
module tick_divider #(
   parameter W = 14
) (
   input  wire         clk_sys,
   input  wire         arst_n,
   input  wire         tick_in,
   input  wire [W-1:0] divisor,
   output reg          tick_out
);
   reg  [W-1:0] cnt_q;

   // divisor 0 is reserved: no output ticks at all
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q    <= {W{1'b0}};
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in && divisor != {W{1'b0}}) begin
            if (cnt_q >= divisor - 1'b1) begin
               cnt_q    <= {W{1'b0}};
               tick_out <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end
endmodule // tick_divider
`default_nettype wire

// file: verilog/lock_counter.v
// digital lock detect: counts consecutive in-window phase detector cycles
`timescale 1ns/1ns
`default_nettype none
module lock_counter (
   input  wire        clk_sys,
   input  wire        arst_n,
   input  wire        pd_tick,
   input  wire [15:0] phase_err_ps,
   input  wire [15:0] window_ps,
   input  wire [13:0] target,
   output reg         locked
);
   reg  [13:0] cnt_q;
   wire        in_win = phase_err_ps < window_ps;
   wire [13:0] cnt_d  = (cnt_q == 14'h3fff) ? cnt_q : cnt_q + 14'h0001;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q  <= 14'h0000;
         locked <= 1'b0;
      end else if (pd_tick) begin
         if (in_win) begin
            cnt_q  <= cnt_d;
            // target 0 is reserved and never locks
            locked <= (target != 14'h0000) && (cnt_d >= target);
         end else begin
            cnt_q  <= 14'h0000;
            locked <= 1'b0;
         end
      end
   end
endmodule // lock_counter
`default_nettype wire

// file: verilog/pll_config_lock_detect.v
// serial-programmed configuration, dividers and lock detect for both loops
`timescale 1ns/1ns
`default_nettype none
`include "pll_cfg_consts.vh"
module pll_config_lock_detect (
   input  wire        clk_sys,
   input  wire        arst_n,
   // serial programming pins
   input  wire        ser_clk,
   input  wire        ser_data,
   input  wire        ser_le,
   output wire        ser_dout,
   // reference ticks and phase detector events
   input  wire        ref0_tick,
   input  wire        ref1_tick,
   input  wire        active_input,
   input  wire        osc_level,
   input  wire        pd1_tick,
   input  wire [15:0] pd1_phase_err,
   input  wire        pd2_tick,
   input  wire [15:0] pd2_phase_err,
   // holdover tracking
   input  wire        holdover_tracking,
   input  wire [9:0]  dac_track_value,
   // lock and divided clocks
   output wire        first_loop_locked,
   output wire        second_loop_locked,
   output wire        dac_update_tick,
   output wire        first_ref_tick,
   output wire        second_ref_tick,
   // loop filter and delay settings
   output wire [3:0]  second_loop_cap_c4,
   output wire [3:0]  second_loop_cap_c3,
   output wire [2:0]  second_loop_res_r4,
   output wire [2:0]  second_loop_res_r3,
   output reg  [10:0] first_loop_feedback_delay,
   output reg  [10:0] first_loop_reference_delay,
   // charge pumps
   output wire        first_loop_pump_polarity,
   output reg  [11:0] first_loop_pump_current,
   output reg         first_pump_output_pin_oe_n,
   output wire        second_loop_pump_polarity,
   output reg  [11:0] second_loop_pump_current,
   output reg         second_pump_output_pin_oe_n,
   output wire        second_loop_ref_doubler
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg  [2:0]  sclk_s;
   reg  [2:0]  sdat_s;
   reg  [2:0]  sle_s;
   reg         sclk_q;
   reg         sdat_q;
   reg         sle_q;
   reg         sclk_prev_q;
   reg         sle_prev_q;

   // a change counts only once the second and third stage agree
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sclk_s      <= 3'h0;
         sdat_s      <= 3'h0;
         sle_s       <= 3'h7;
         sclk_q      <= 1'b0;
         sdat_q      <= 1'b0;
         sle_q       <= 1'b1;
         sclk_prev_q <= 1'b0;
         sle_prev_q  <= 1'b1;
      end else begin
         sclk_s <= {sclk_s[1:0], ser_clk};
         sdat_s <= {sdat_s[1:0], ser_data};
         sle_s  <= {sle_s[1:0], ser_le};
         if (sclk_s[1] == sclk_s[2]) begin
            sclk_q <= sclk_s[2];
         end
         if (sdat_s[1] == sdat_s[2]) begin
            sdat_q <= sdat_s[2];
         end
         if (sle_s[1] == sle_s[2]) begin
            sle_q <= sle_s[2];
         end
         sclk_prev_q <= sclk_q;
         sle_prev_q  <= sle_q;
      end
   end

   wire sclk_rise = sclk_q & ~sclk_prev_q;
   wire sclk_fall = ~sclk_q & sclk_prev_q;
   wire le_rise   = sle_q & ~sle_prev_q;

   // ----------------------------------------
   // register file
   // ----------------------------------------
   reg  [31:0] shift_q;
   reg  [31:0] filt_dly_q;
   reg  [31:0] div_cnt_q;
   reg  [31:0] loop2_q;
   reg  [31:0] loop1_q;
   reg  [31:0] ref2_q;
   reg  [4:0]  rb_addr_q;
   reg  [31:0] rb_shift_q;
   reg  [9:0]  dac_count_q;
   reg  [31:0] rb_word;

   wire [4:0]  wr_addr = shift_q[`F_ADDR];

   // selected register image for readback
   always @* begin
      case (rb_addr_q)
         `ADDR_DAC_COUNT_READBACK: begin
            rb_word = 32'h0000_0000;
            rb_word[`F_DAC_COUNT] = dac_count_q;
            rb_word[`F_ADDR] = `ADDR_DAC_COUNT_READBACK;
         end
         `ADDR_LOOP_FILTER_DELAY: begin
            rb_word = filt_dly_q;
         end
         `ADDR_DAC_DIV_LOCK_COUNT: begin
            rb_word = div_cnt_q;
         end
         `ADDR_SECOND_LOOP_CTRL: begin
            rb_word = loop2_q;
         end
         `ADDR_FIRST_LOOP_CTRL: begin
            rb_word = loop1_q;
         end
         `ADDR_SECOND_LOOP_REF_DIV: begin
            rb_word = ref2_q;
         end
         default: begin
            rb_word = 32'h0000_0000;
         end
      endcase
   end

   // shift in msb first while le is low, commit on le rising edge
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         shift_q    <= `RST_REG;
         filt_dly_q <= `RST_REG;
         div_cnt_q  <= `RST_REG;
         loop2_q    <= `RST_REG;
         loop1_q    <= `RST_REG;
         ref2_q     <= `RST_REG;
         rb_addr_q  <= `ADDR_DAC_COUNT_READBACK;
         rb_shift_q <= `RST_REG;
      end else begin
         if (sclk_rise && !sle_q) begin
            shift_q <= {shift_q[30:0], sdat_q};
         end
         if (sclk_fall && !sle_q) begin
            rb_shift_q <= {rb_shift_q[30:0], 1'b0};
         end
         if (le_rise) begin
            case (wr_addr)
               `ADDR_LOOP_FILTER_DELAY: begin
                  filt_dly_q <= {shift_q[31:5], `ADDR_LOOP_FILTER_DELAY};
               end
               `ADDR_DAC_DIV_LOCK_COUNT: begin
                  div_cnt_q <= {shift_q[31:5], `ADDR_DAC_DIV_LOCK_COUNT};
               end
               `ADDR_SECOND_LOOP_CTRL: begin
                  loop2_q <= {shift_q[31:5], `ADDR_SECOND_LOOP_CTRL};
               end
               `ADDR_FIRST_LOOP_CTRL: begin
                  loop1_q <= {shift_q[31:5], `ADDR_FIRST_LOOP_CTRL};
               end
               `ADDR_SECOND_LOOP_REF_DIV: begin
                  ref2_q <= {shift_q[31:5], `ADDR_SECOND_LOOP_REF_DIV};
               end
               `ADDR_READBACK_SELECT: begin
                  rb_addr_q <= shift_q[`F_RB_ADDR];
               end
               default: begin
                  // readback-only and unmapped addresses are dropped
                  rb_addr_q <= rb_addr_q;
               end
            endcase
         end
         // readback image loads as le falls after the select frame
         if (!sle_q && sle_prev_q) begin
            rb_shift_q <= rb_word;
         end
      end
   end

   assign ser_dout = rb_shift_q[31];

   // ----------------------------------------
   // tuning dac count and update clock
   // ----------------------------------------
   tick_divider #(
      .W        (10)
   ) u_dac_div (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .tick_in  (pd1_tick),
      .divisor  (div_cnt_q[`F_DAC_DIV]),
      .tick_out (dac_update_tick)
   );

   // the tracked value is captured on each dac update while holdover tracking is on
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         dac_count_q <= 10'h000;
      end else if (dac_update_tick && holdover_tracking) begin
         dac_count_q <= dac_track_value;
      end
   end

   // ----------------------------------------
   // first-loop reference path
   // ----------------------------------------
   wire       pre0_tick;
   wire       pre1_tick;
   wire [3:0] pre0_div = 4'h1 << loop1_q[`F_PREDIV0];
   wire [3:0] pre1_div = 4'h1 << loop1_q[`F_PREDIV1];

   tick_divider #(
      .W        (4)
   ) u_pre0 (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .tick_in  (ref0_tick),
      .divisor  (pre0_div),
      .tick_out (pre0_tick)
   );

   tick_divider #(
      .W        (4)
   ) u_pre1 (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .tick_in  (ref1_tick),
      .divisor  (pre1_div),
      .tick_out (pre1_tick)
   );

   // switching inputs picks that input's own pre-divider output
   wire pre_sel_tick = active_input ? pre1_tick : pre0_tick;

   tick_divider #(
      .W        (14)
   ) u_ref1 (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .tick_in  (pre_sel_tick),
      .divisor  (loop1_q[`F_REF_DIV1]),
      .tick_out (first_ref_tick)
   );

   // ----------------------------------------
   // second-loop reference path
   // ----------------------------------------
   reg  [2:0] osc_s;
   reg        osc_prev_q;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         osc_s      <= 3'h0;
         osc_prev_q <= 1'b0;
      end else begin
         osc_s <= {osc_s[1:0], osc_level};
         if (osc_s[1] == osc_s[2]) begin
            osc_prev_q <= osc_s[2];
         end
      end
   end

   reg  osc_last_q;
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         osc_last_q <= 1'b0;
      end else begin
         osc_last_q <= osc_prev_q;
      end
   end

   // doubler counts both edges of the reference instead of rising only
   wire osc_rise = osc_prev_q & ~osc_last_q;
   wire osc_edge = osc_prev_q ^ osc_last_q;
   wire osc_tick = loop2_q[`F_DOUBLER] ? osc_edge : osc_rise;

   tick_divider #(
      .W        (12)
   ) u_ref2 (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .tick_in  (osc_tick),
      .divisor  (ref2_q[`F_REF_DIV2]),
      .tick_out (second_ref_tick)
   );

   assign second_loop_ref_doubler = loop2_q[`F_DOUBLER];

   // ----------------------------------------
   // lock detect
   // ----------------------------------------
   reg  [15:0] win1_ps;

   always @* begin
      case (filt_dly_q[`F_WINDOW1])
         2'h0: win1_ps = `WIN1_PS_0;
         2'h1: win1_ps = `WIN1_PS_1;
         2'h2: win1_ps = `WIN1_PS_2;
         default: win1_ps = `WIN1_PS_3;
      endcase
   end

   lock_counter u_lock1 (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .pd_tick      (pd1_tick),
      .phase_err_ps (pd1_phase_err),
      .window_ps    (win1_ps),
      .target       (div_cnt_q[`F_LOCK_COUNT]),
      .locked       (first_loop_locked)
   );

   // only the 3.7 ns code is defined, so every code uses it
   lock_counter u_lock2 (
      .clk_sys      (clk_sys),
      .arst_n       (arst_n),
      .pd_tick      (pd2_tick),
      .phase_err_ps (pd2_phase_err),
      .window_ps    (`WIN2_PS),
      .target       (loop2_q[`F_LOCK_COUNT]),
      .locked       (second_loop_locked)
   );

   // ----------------------------------------
   // loop filter, delays and charge pumps
   // ----------------------------------------
   assign second_loop_cap_c4 = filt_dly_q[`F_CAP_C4];
   assign second_loop_cap_c3 = filt_dly_q[`F_CAP_C3];
   assign second_loop_res_r4 = filt_dly_q[`F_RES_R4];
   assign second_loop_res_r3 = filt_dly_q[`F_RES_R3];
   assign first_loop_pump_polarity  = loop1_q[`F_PUMP_POL];
   assign second_loop_pump_polarity = loop2_q[`F_PUMP_POL];

   reg  [11:0] p1_ua;
   reg  [11:0] p2_ua;

   always @* begin
      case (loop1_q[`F_PUMP_GAIN])
         2'h0: p1_ua = `P1_UA_0;
         2'h1: p1_ua = `P1_UA_1;
         2'h2: p1_ua = `P1_UA_2;
         default: p1_ua = `P1_UA_3;
      endcase
      case (loop2_q[`F_PUMP_GAIN])
         2'h0: p2_ua = `P2_UA_0;
         2'h1: p2_ua = `P2_UA_1;
         2'h2: p2_ua = `P2_UA_2;
         default: p2_ua = `P2_UA_3;
      endcase
   end

   // hiz forces the pin off and the current to zero whatever the gain
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         first_loop_feedback_delay   <= 11'h000;
         first_loop_reference_delay  <= 11'h000;
         first_loop_pump_current     <= 12'h000;
         second_loop_pump_current    <= 12'h000;
         first_pump_output_pin_oe_n  <= 1'b1;
         second_pump_output_pin_oe_n <= 1'b1;
      end else begin
         first_loop_feedback_delay  <= filt_dly_q[`F_FB_DELAY] * `DELAY_STEP_PS;
         first_loop_reference_delay <= filt_dly_q[`F_REF_DELAY] * `DELAY_STEP_PS;
         first_pump_output_pin_oe_n <= loop1_q[`F_PUMP_HIZ];
         first_loop_pump_current    <= loop1_q[`F_PUMP_HIZ] ? 12'h000 : p1_ua;
         second_pump_output_pin_oe_n <= loop2_q[`F_PUMP_HIZ];
         second_loop_pump_current    <= loop2_q[`F_PUMP_HIZ] ? 12'h000 : p2_ua;
      end
   end
endmodule // pll_config_lock_detect
`default_nettype wire

// file: test/pll_config_lock_detect_chk.sv
// pin-level assertions for the configuration and lock-detect block
`timescale 1ns/1ns
`default_nettype none
module pll_cfg_chk (
   input wire logic        clk_sys,
   input wire logic        arst_n,
   input wire logic        pd1_tick,
   input wire logic [15:0] pd1_phase_err,
   input wire logic        pd2_tick,
   input wire logic [15:0] pd2_phase_err,
   input wire logic        first_loop_locked,
   input wire logic        second_loop_locked,
   input wire logic        dac_update_tick,
   input wire logic [10:0] first_loop_feedback_delay,
   input wire logic [10:0] first_loop_reference_delay,
   input wire logic [11:0] first_loop_pump_current,
   input wire logic        first_pump_output_pin_oe_n,
   input wire logic [11:0] second_loop_pump_current,
   input wire logic        second_pump_output_pin_oe_n
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_pump1_hiz: assert property (first_pump_output_pin_oe_n |->
      first_loop_pump_current == 12'h000) else $error("first pump current while hiz");
   a_pump2_hiz: assert property (second_pump_output_pin_oe_n |->
      second_loop_pump_current == 12'h000) else $error("second pump current while hiz");
   a_pump1_level: assert property (!first_pump_output_pin_oe_n |->
      first_loop_pump_current inside {12'h064, 12'h0c8, 12'h190, 12'h640}) else $error("first pump level");
   a_pump2_level: assert property (!second_pump_output_pin_oe_n |->
      second_loop_pump_current inside {12'h064, 12'h190, 12'h640, 12'hc80}) else $error("second pump level");
   a_fb_delay_step: assert property (first_loop_feedback_delay % 11'h0cd == 11'h000 &&
      first_loop_feedback_delay <= 11'h59b) else $error("feedback delay step");
   a_ref_delay_step: assert property (first_loop_reference_delay % 11'h0cd == 11'h000 &&
      first_loop_reference_delay <= 11'h59b) else $error("reference delay step");
   a_lock1_drop: assert property (pd1_tick && pd1_phase_err >= 16'h9c40 |=> !first_loop_locked)
      else $error("first lock held after wide error");
   a_lock2_drop: assert property (pd2_tick && pd2_phase_err >= 16'h0e74 |=> !second_loop_locked)
      else $error("second lock held after wide error");
   a_lock1_cause: assert property ($rose(first_loop_locked) |-> $past(pd1_tick))
      else $error("first lock rose without tick");
   a_lock2_cause: assert property ($rose(second_loop_locked) |->
      $past(pd2_tick) && $past(pd2_phase_err) < 16'h0e74) else $error("second lock rose without good tick");
   a_dac_tick_cause: assert property (dac_update_tick |-> $past(pd1_tick))
      else $error("dac tick without phase detector tick");
endmodule // pll_cfg_chk
bind pll_config_lock_detect pll_cfg_chk chk (.*);
`default_nettype wire

// file: test/serial_host.sv
// host model driving the serial programming pins
`timescale 1ns/1ns
`default_nettype none
module serial_host (
   input  wire logic clk_sys,
   output var logic  ser_clk,
   output var logic  ser_data,
   output var logic  ser_le,
   input  wire logic ser_dout
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      ser_le = 1'b1;
   end
   // six cycles per level, twice the synchroniser depth
   task automatic hold6;
      repeat (6) @(posedge clk_sys);
      #1;
   endtask
   // msb first, committed by the latch enable rise
   task automatic write_reg(input logic [31:0] w);
      ser_le = 1'b0;
      for (int i = 31; i >= 0; i--) begin
         ser_data = w[i];
         hold6();
         ser_clk = 1'b1;
         hold6();
         ser_clk = 1'b0;
      end
      hold6();
      ser_data = ~ser_data;
      ser_le = 1'b1;
      hold6();
   endtask
   // select, then shift out on falling serial clock; latch enable stays low after
   task automatic read_reg(input logic [4:0] a, output logic [31:0] d);
      write_reg({11'h000, a, 11'h000, 5'h1f});
      ser_le = 1'b0;
      hold6();
      for (int i = 31; i >= 0; i--) begin
         d[i] = ser_dout;
         if (i > 0) begin
            ser_clk = 1'b1;
            hold6();
            ser_clk = 1'b0;
            hold6();
         end
      end
   endtask
endmodule // serial_host
`default_nettype wire

// file: test/tb_pll_config_lock_detect.sv
// self-checking bench for the configuration and lock-detect block
`timescale 1ns/1ns
`default_nettype none
module tb_pll_config_lock_detect;
   logic        clk_sys = 1'b0, arst_n = 1'b0, ser_clk, ser_data, ser_le, ser_dout;
   logic        ref0_tick = 1'b0, ref1_tick = 1'b0, active_input = 1'b0, osc_level = 1'b0;
   logic        pd1_tick = 1'b0, pd2_tick = 1'b0, holdover_tracking = 1'b0;
   logic [15:0] pd1_phase_err = 16'h0000, pd2_phase_err = 16'h0000;
   logic [9:0]  dac_track_value = 10'h000;
   logic        first_loop_locked, second_loop_locked, dac_update_tick, first_ref_tick, second_ref_tick;
   logic [3:0]  second_loop_cap_c4, second_loop_cap_c3;
   logic [2:0]  second_loop_res_r4, second_loop_res_r3;
   logic [10:0] first_loop_feedback_delay, first_loop_reference_delay;
   logic        first_loop_pump_polarity, first_pump_output_pin_oe_n, second_loop_ref_doubler;
   logic        second_loop_pump_polarity, second_pump_output_pin_oe_n;
   logic [11:0] first_loop_pump_current, second_loop_pump_current;
   logic [15:0] win [4] = '{16'h157c, 16'h2710, 16'h48a8, 16'h9c40};
   logic [11:0] p1 [4] = '{12'h064, 12'h0c8, 12'h190, 12'h640};
   logic [11:0] p2 [4] = '{12'h064, 12'h190, 12'h640, 12'hc80};
   logic [31:0] rd;
   int          error_cnt = 0, cmp_count = 0, n_dac = 0, n_ref1 = 0, n_ref2 = 0;

   always #2 clk_sys = ~clk_sys;
   pll_config_lock_detect uut (.*);
   serial_host host (.clk_sys(clk_sys), .ser_clk(ser_clk), .ser_data(ser_data), .ser_le(ser_le),
      .ser_dout(ser_dout));
   always @(posedge clk_sys) begin
      if (dac_update_tick === 1'b1) n_dac++;
      if (first_ref_tick === 1'b1) n_ref1++;
      if (second_ref_tick === 1'b1) n_ref2++;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [31:0] w);
      host.write_reg(w);
      cyc(8);
   endtask
   task automatic pd(input logic l2, input logic [15:0] e);
      if (l2) begin
         pd2_tick = 1'b1;
         pd2_phase_err = e;
      end else begin
         pd1_tick = 1'b1;
         pd1_phase_err = e;
      end
      cyc(1);
      pd1_tick = 1'b0;
      pd2_tick = 1'b0;
      cyc(2);
   endtask
   task automatic rtick(input logic i);
      ref0_tick = !i;
      ref1_tick = i;
      cyc(1);
      ref0_tick = 1'b0;
      ref1_tick = 1'b0;
      cyc(1);
   endtask
   task automatic osc(input int n);
      repeat (n) begin
         osc_level = ~osc_level;
         cyc(8);
      end
   endtask
   function automatic logic [31:0] f18(input logic [2:0] k, input logic [1:0] w);
      return {4'hd, 4'h7, 1'b0, 3'h4, 1'b0, 3'h2, 1'b0, k, 1'b0, 3'h7 - k, w, 1'b0, 5'h18};
   endfunction
   function automatic logic [31:0] f1a(input logic [1:0] g, input logic h, input logic [13:0] n);
      return {2'h2, g[1], 1'b0, g, 6'h00, n, h, 5'h1a};
   endfunction
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_reset;
      chk("locks", 2'h0, {first_loop_locked, second_loop_locked});
      chk("oe_n", 2'h3, {first_pump_output_pin_oe_n, second_pump_output_pin_oe_n});
      chk("currents", 24'h0, {first_loop_pump_current, second_loop_pump_current});
      $display("test reset done");
   endtask
   task automatic t_delay;
      for (int k = 0; k < 8; k++) begin
         wr(f18(3'(k), 2'h0));
         chk("fb_delay", k * 205, first_loop_feedback_delay);
         chk("ref_delay", (7 - k) * 205, first_loop_reference_delay);
      end
      chk("filter", 14'h35e2, {second_loop_cap_c4, second_loop_cap_c3, second_loop_res_r4, second_loop_res_r3});
      $display("test delay done");
   endtask
   task automatic t_lock1;
      wr({10'h003, 2'h0, 14'h0001, 6'h19});
      for (int w = 0; w < 4; w++) begin
         wr(f18(3'h7, 2'(w)));
         pd(1'b0, win[w]);
         chk("lock1_edge", 1'b0, first_loop_locked);
         pd(1'b0, win[w] - 16'h0001);
         chk("lock1_in", 1'b1, first_loop_locked);
         pd(1'b0, win[w]);
         chk("lock1_out", 1'b0, first_loop_locked);
      end
      wr({10'h003, 2'h0, 14'h0004, 6'h19});
      repeat (3) pd(1'b0, 16'h0064);
      chk("lock1_early", 1'b0, first_loop_locked);
      pd(1'b0, 16'h0064);
      chk("lock1_count", 1'b1, first_loop_locked);
      pd(1'b0, 16'h9c40);
      repeat (3) pd(1'b0, 16'h0064);
      chk("lock1_restart", 1'b0, first_loop_locked);
      $display("test lock1 done");
   endtask
   task automatic t_pumps;
      for (int g = 0; g < 4; g++) for (int h = 0; h < 2; h++) begin
         wr(f1a(2'(g), h[0], 14'h0002));
         wr({3'h0, g[0], 2'(g), 2'h0, 2'h2, 2'h1, 14'h0003, h[0], 5'h1b});
         chk("cur2", h ? 12'h000 : p2[g], second_loop_pump_current);
         chk("oe2_n", h, second_pump_output_pin_oe_n);
         chk("cur1", h ? 12'h000 : p1[g], first_loop_pump_current);
         chk("oe1_n", h, first_pump_output_pin_oe_n);
         chk("pol", {g[0], 1'b0}, {first_loop_pump_polarity, second_loop_pump_polarity});
         chk("dbl", g[1], second_loop_ref_doubler);
      end
      $display("test pumps done");
   endtask
   task automatic t_lock2;
      pd(1'b1, 16'h0e73);
      chk("lock2_early", 1'b0, second_loop_locked);
      pd(1'b1, 16'h0e73);
      chk("lock2_count", 1'b1, second_loop_locked);
      pd(1'b1, 16'h0e74);
      chk("lock2_out", 1'b0, second_loop_locked);
      $display("test lock2 done");
   endtask
   task automatic t_refdiv;
      n_ref1 = 0;
      repeat (24) rtick(1'b0);
      cyc(2);
      chk("ref_in0", 4, n_ref1);
      active_input = 1'b1;
      n_ref1 = 0;
      repeat (24) rtick(1'b1);
      cyc(2);
      chk("ref_in1", 2, n_ref1);
      wr({12'h002, 15'h0000, 5'h1c});
      n_ref2 = 0;
      osc(16);
      chk("ref2_dbl", 8, n_ref2);
      wr(f1a(2'h1, 1'b0, 14'h0002));
      n_ref2 = 0;
      osc(16);
      chk("ref2", 4, n_ref2);
      $display("test refdiv done");
   endtask
   task automatic t_readback;
      wr(32'hffff_fff7);
      wr(32'hffff_ffe5);
      holdover_tracking = 1'b1;
      dac_track_value = 10'h2a5;
      n_dac = 0;
      repeat (6) pd(1'b0, 16'h0064);
      chk("dac_ticks", 2, n_dac);
      host.read_reg(5'h17, rd);
      chk("rb_dac", {8'h00, 10'h2a5, 9'h000, 5'h17}, rd);
      host.read_reg(5'h18, rd);
      chk("rb_filter", f18(3'h7, 2'h3), rd);
      $display("test readback done");
   endtask
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys);
      error_cnt++;
      finish_test();
   end
   initial begin
      repeat (12) @(posedge clk_sys);
      #1;
      t_reset();
      arst_n = 1'b1;
      cyc(4);
      t_delay();
      t_lock1();
      t_pumps();
      t_lock2();
      t_refdiv();
      t_readback();
      finish_test();
   end
endmodule // tb_pll_config_lock_detect
`default_nettype wire
